// ### hdl/nvmc_ctrl.sv
// Purpose: Host controller for a nonvolatile SRAM with sleep and command sequences
// Assumes: Far device on asynchronous pins, busy and data inputs unsynchronised
// Notes:   One request at a time; REQ_READY_O low until the controller is back in idle, or while sleep is requested
`default_nettype none
module nvmc_ctrl
	import nvmc_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CNT,
	parameter bit WIDE16      = 1'b1
)(
	// System
	input  wire logic              SYS_CLK_I,
	input  wire logic              RSTN_I,
	// Request port
	input  wire logic              REQ_VALID_I,
	input  wire nvmc_pkg::nvmc_op_t REQ_OP_I,
	input  wire logic [20:0]       REQ_ADDR_I,
	input  wire logic [15:0]       REQ_WDATA_I,
	input  wire logic [1:0]        REQ_BE_I,
	output logic                   REQ_READY_O,
	output logic                   RSP_VALID_O,
	output logic [15:0]            RSP_RDATA_O,
	output logic                   AUTOSAVE_ON_O,
	// Sleep control
	input  wire logic              SLEEP_REQ_I,
	output logic                   ASLEEP_O,
	// Device pins
	output logic                   CHIP_SELECT_FIRST_N_O,
	output logic                   CHIP_SELECT_SECOND_O,
	output logic                   WE_N_O,
	output logic                   OE_N_O,
	output logic                   UPPER_BYTE_ENABLE_N_O,
	output logic                   LOWER_BYTE_ENABLE_N_O,
	output logic [20:0]            ADDR_O,
	output logic [15:0]            DQ_O,
	output logic                   DQ_OE_O,
	input  wire logic [15:0]       DQ_I,
	output logic                   SLEEP_REQUEST_N_O,
	input  wire logic              STORE_BUSY_N_I
);
	typedef enum logic [2:0] {
		NVMC_IDLE, NVMC_CYC, NVMC_BUSYWAIT, NVMC_SLEEP, NVMC_WAKE, NVMC_ASFIX
	} nvmc_state_t;

	nvmc_state_t state_q, state_d;
	nvmc_cyc_if  cyc ();
	logic [15:0] dq_s1_q, dq_s2_q;
	logic        busy_s1_q, busy_s2_q;
	logic [2:0]  step_q;
	nvmc_op_t    op_q;
	logic [20:0] addr_q;
	logic [15:0] wdata_q;
	logic [1:0]  be_q;
	logic [15:0] wait_q;
	logic        start_q;
	logic        cs_n, we_n, oe_n;
	logic [1:0]  be_n;
	logic [20:0] pin_addr;
	logic [15:0] pin_dq;
	logic        pin_oe;

	// Command address for each step of a six-read sequence
	wire         is_cmd  = (op_q != NVMC_OP_READ) && (op_q != NVMC_OP_WRITE);
	wire [15:0]  last_ad = (op_q == NVMC_OP_SAVE)    ? CMD_SAVE :
	                       (op_q == NVMC_OP_RESTORE) ? CMD_RESTORE :
	                       (op_q == NVMC_OP_AS_OFF)  ? CMD_AS_OFF : CMD_AS_ON;
	wire [15:0]  seq_ad  = (step_q == 3'd0) ? SEQ_0 : (step_q == 3'd1) ? SEQ_1 :
	                       (step_q == 3'd2) ? SEQ_2 : (step_q == 3'd3) ? SEQ_3 :
	                       (step_q == 3'd4) ? SEQ_4 : last_ad;
	wire         seq_end = is_cmd && (step_q == 3'd5);
	wire         take    = (state_q == NVMC_IDLE) && REQ_VALID_I && !SLEEP_REQ_I &&
	                       REQ_READY_O;
	wire         busy    = !busy_s2_q;
	wire         chg_as  = (op_q == NVMC_OP_AS_OFF) || (op_q == NVMC_OP_AS_ON);

	assign cyc.start = start_q;
	assign cyc.wr    = (op_q == NVMC_OP_WRITE);
	assign cyc.addr  = is_cmd ? {5'h00, seq_ad} : addr_q;
	assign cyc.wdata = wdata_q;
	assign cyc.be    = WIDE16 ? be_q : 2'b11;

	nvmc_cycle u_cycle (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RSTN_I),
		.cyc     (cyc),
		.cs_n_o  (cs_n),
		.we_n_o  (we_n),
		.oe_n_o  (oe_n),
		.be_n_o  (be_n),
		.addr_o  (pin_addr),
		.dq_o    (pin_dq),
		.dq_oe_o (pin_oe),
		.dq_i    (dq_s2_q)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			NVMC_IDLE:     if (SLEEP_REQ_I) state_d = NVMC_SLEEP;
			               else if (take) state_d = busy ? NVMC_BUSYWAIT : NVMC_CYC;
			NVMC_CYC:      if (cyc.done && (!is_cmd || seq_end))
			                   state_d = is_cmd ? NVMC_BUSYWAIT : NVMC_IDLE;
			// wait for busy release; a held-off command still runs
			NVMC_BUSYWAIT: if (!busy && wait_q == 16'h0000 && !start_q)
			                   state_d = (chg_as && step_q == 3'd5) ? NVMC_ASFIX :
			                             (step_q == 3'd5) ? NVMC_IDLE : NVMC_CYC;
			NVMC_ASFIX:    state_d = NVMC_CYC;
			NVMC_SLEEP:    if (!SLEEP_REQ_I) state_d = NVMC_WAKE;
			NVMC_WAKE:     if (wait_q == 16'h0000) state_d = NVMC_IDLE;
			default:       state_d = NVMC_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			dq_s1_q   <= 16'h0000;
			dq_s2_q   <= 16'h0000;
			busy_s1_q <= 1'b1;
			busy_s2_q <= 1'b1;
		end else begin
			dq_s1_q   <= DQ_I;
			dq_s2_q   <= dq_s1_q;
			busy_s1_q <= STORE_BUSY_N_I;
			busy_s2_q <= busy_s1_q;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_q <= NVMC_IDLE;
			op_q    <= NVMC_OP_READ;
			addr_q  <= 21'h00_0000;
			wdata_q <= 16'h0000;
			be_q    <= 2'b00;
			step_q  <= 3'd0;
			start_q <= 1'b0;
			wait_q  <= 16'h0000;
		end else begin
			state_q <= state_d;
			start_q <= 1'b0;
			if (wait_q != 16'h0000)
				wait_q <= wait_q - 16'h0001;
			if (take) begin
				op_q    <= REQ_OP_I;
				addr_q  <= REQ_ADDR_I;
				wdata_q <= REQ_WDATA_I;
				be_q    <= REQ_BE_I;
				step_q  <= 3'd0;
				start_q <= !busy;
				wait_q  <= 16'(BUSY_CNT);
			end else if (state_q == NVMC_CYC && cyc.done && is_cmd && !seq_end) begin
				step_q  <= step_q + 3'd1;
				start_q <= 1'b1;
			end else if (state_q == NVMC_CYC && cyc.done && seq_end) begin
				wait_q  <= 16'(BUSY_CNT);
			end else if (state_q == NVMC_BUSYWAIT && state_d == NVMC_CYC) begin
				start_q <= 1'b1;
			end else if (state_d == NVMC_ASFIX) begin
				op_q    <= NVMC_OP_SAVE;
				step_q  <= 3'd0;
			end else if (state_q == NVMC_ASFIX) begin
				start_q <= 1'b1;
			end else if (state_q == NVMC_SLEEP && state_d == NVMC_WAKE) begin
				wait_q  <= 16'(WAKE_CYCLES);
			end
			// Busy must not cut the wake-up delay short
			if (busy && state_q != NVMC_SLEEP && state_q != NVMC_WAKE)
				wait_q <= 16'(BUSY_CNT);
		end
	end

	// Outputs registered at the top
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			REQ_READY_O           <= 1'b0;
			RSP_VALID_O           <= 1'b0;
			RSP_RDATA_O           <= 16'h0000;
			AUTOSAVE_ON_O         <= 1'b1;
			ASLEEP_O              <= 1'b0;
			CHIP_SELECT_FIRST_N_O <= 1'b1;
			CHIP_SELECT_SECOND_O  <= 1'b0;
			WE_N_O                <= 1'b1;
			OE_N_O                <= 1'b1;
			UPPER_BYTE_ENABLE_N_O <= 1'b1;
			LOWER_BYTE_ENABLE_N_O <= 1'b1;
			ADDR_O                <= 21'h00_0000;
			DQ_O                  <= 16'h0000;
			DQ_OE_O               <= 1'b0;
			SLEEP_REQUEST_N_O     <= 1'b1;
		end else begin
			REQ_READY_O           <= (state_d == NVMC_IDLE) && !SLEEP_REQ_I;
			RSP_VALID_O           <= (state_q == NVMC_CYC && cyc.done && !is_cmd) ||
			                         (state_q == NVMC_BUSYWAIT && state_d == NVMC_IDLE);
			if (state_q == NVMC_CYC && cyc.done && !is_cmd)
				RSP_RDATA_O <= cyc.rdata;
			if (state_q == NVMC_CYC && seq_end && cyc.done && op_q == NVMC_OP_AS_OFF)
				AUTOSAVE_ON_O <= 1'b0;
			if (state_q == NVMC_CYC && seq_end && cyc.done && op_q == NVMC_OP_AS_ON)
				AUTOSAVE_ON_O <= 1'b1;
			ASLEEP_O              <= (state_d == NVMC_SLEEP);
			SLEEP_REQUEST_N_O     <= !(state_d == NVMC_SLEEP);
			CHIP_SELECT_FIRST_N_O <= cs_n;
			CHIP_SELECT_SECOND_O  <= !cs_n;
			WE_N_O                <= we_n;
			OE_N_O                <= oe_n;
			UPPER_BYTE_ENABLE_N_O <= be_n[1];
			LOWER_BYTE_ENABLE_N_O <= be_n[0];
			ADDR_O                <= pin_addr;
			DQ_O                  <= pin_dq;
			DQ_OE_O               <= pin_oe;
		end
	end
endmodule
`default_nettype wire

// ### hdl/nvmc_cycle.sv
// Purpose: One asynchronous SRAM read or write cycle on the pins
// Assumes: Read data pins already synchronised by the caller
// Notes:   Cycle length fixed by CYCLE_CNT
`default_nettype none
module nvmc_cycle
	import nvmc_pkg::*;
(
	// System
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Request side
	nvmc_cyc_if.eng          cyc,
	// Pin side
	output logic             cs_n_o,
	output logic             we_n_o,
	output logic             oe_n_o,
	output logic [1:0]       be_n_o,
	output logic [20:0]      addr_o,
	output logic [15:0]      dq_o,
	output logic             dq_oe_o,
	input  wire logic [15:0] dq_i
);
	logic [7:0] cnt_q;
	logic       act_q;
	logic       wr_q;
	logic [15:0] rd_q;
	logic       done_q;
	logic       fin_q;
	wire        last = act_q && (cnt_q == 8'(CYCLE_CNT - 1));

	assign cyc.done  = done_q;
	assign cyc.rdata = rd_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_q   <= 1'b0;
			cnt_q   <= 8'h00;
			wr_q    <= 1'b0;
			done_q  <= 1'b0;
			fin_q   <= 1'b0;
			rd_q    <= 16'h0000;
			cs_n_o  <= 1'b1;
			we_n_o  <= 1'b1;
			oe_n_o  <= 1'b1;
			be_n_o  <= 2'b11;
			addr_o  <= 21'h00_0000;
			dq_o    <= 16'h0000;
			dq_oe_o <= 1'b0;
		end else begin
			// Pins and both sync flops lag the engine, so data is taken an edge late
			fin_q  <= last;
			done_q <= fin_q;
			if (fin_q && !wr_q)
				rd_q <= dq_i;
			if (cyc.start && !act_q) begin
				act_q   <= 1'b1;
				cnt_q   <= 8'h00;
				wr_q    <= cyc.wr;
				cs_n_o  <= 1'b0;
				we_n_o  <= ~cyc.wr;
				oe_n_o  <= cyc.wr;
				be_n_o  <= ~cyc.be;
				addr_o  <= cyc.addr;
				dq_o    <= cyc.wdata;
				dq_oe_o <= cyc.wr;
			end else if (last) begin
				act_q   <= 1'b0;
				cs_n_o  <= 1'b1;
				we_n_o  <= 1'b1;
				oe_n_o  <= 1'b1;
				be_n_o  <= 2'b11;
				dq_oe_o <= 1'b0;
			end else if (act_q) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### inc/nvmc_cyc_if.sv
// Purpose: Carrier between sequencer and bus cycle engine
// Assumes: One clock domain
// Notes:   Start is a one-cycle pulse
`default_nettype none
interface nvmc_cyc_if;
	logic        start;
	logic        wr;
	logic [20:0] addr;
	logic [15:0] wdata;
	logic [1:0]  be;
	logic        done;
	logic [15:0] rdata;
	modport ctrl (output start, output wr, output addr, output wdata, output be,
		input done, input rdata);
	modport eng  (input start, input wr, input addr, input wdata, input be,
		output done, output rdata);
endinterface
`default_nettype wire

// ### inc/nvmc_pkg.sv
// Purpose: Constants and types for the host-side nonvolatile SRAM controller
// Assumes: 50 MHz system clock, asynchronous SRAM bus on the far side
// Notes:   Timing counts derive from nanosecond figures at the clock rate
`default_nettype none
package nvmc_pkg;
	localparam int          CLK_PERIOD_NS  = 20;
	localparam int          ADDR_W         = 21;
	localparam int          DATA_W         = 16;
	// Bus cycle and delay times in ns
	localparam int          T_CYCLE_NS     = 60;
	localparam int          T_WAKE_NS      = 20000;
	localparam int          T_BUSY_NS      = 100;
	localparam int          CYCLE_CNT      = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WAKE_CNT       = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          BUSY_CNT       = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Command sequence, address bits 14..2 only matter to the device
	localparam logic [15:0] SEQ_0          = 16'h4E38;
	localparam logic [15:0] SEQ_1          = 16'hB1C7;
	localparam logic [15:0] SEQ_2          = 16'h83E0;
	localparam logic [15:0] SEQ_3          = 16'h7C1F;
	localparam logic [15:0] SEQ_4          = 16'h703F;
	localparam logic [15:0] CMD_AS_OFF     = 16'h8B45;
	localparam logic [15:0] CMD_AS_ON      = 16'h4B46;
	localparam logic [15:0] CMD_SAVE       = 16'h8FC0;
	localparam logic [15:0] CMD_RESTORE    = 16'h4C63;
	localparam logic [20:0] CLK_REG_BASE8  = 21'h1F_FFF0;
	localparam logic [20:0] CLK_REG_BASE16 = 21'h0F_FFF0;
	localparam int          CLK_REG_NUM    = 16;
	typedef enum logic [2:0] {
		NVMC_OP_READ,
		NVMC_OP_WRITE,
		NVMC_OP_SAVE,
		NVMC_OP_RESTORE,
		NVMC_OP_AS_OFF,
		NVMC_OP_AS_ON
	} nvmc_op_t;
endpackage
`default_nettype wire

// ### testbench/nvmc_ctrl_monitor.sv
// Purpose: Pin checks of the nonvolatile SRAM controller
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sees only top ports
`default_nettype none
module nvmc_ctrl_monitor #(
	parameter int WAKE_CYCLES = 4
)(
	// System
	input  wire logic SYS_CLK_I,
	input  wire logic RSTN_I,
	// Request side
	input  wire logic REQ_READY_O,
	input  wire logic SLEEP_REQ_I,
	input  wire logic ASLEEP_O,
	// Device pins
	input  wire logic CHIP_SELECT_FIRST_N_O,
	input  wire logic CHIP_SELECT_SECOND_O,
	input  wire logic WE_N_O,
	input  wire logic OE_N_O,
	input  wire logic DQ_OE_O,
	input  wire logic SLEEP_REQUEST_N_O,
	input  wire logic STORE_BUSY_N_I
);
	logic [15:0] wake_q;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	// Saturates so a plain reset never looks like a fresh wake
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			wake_q <= 16'hFFFF;
		else if (!SLEEP_REQUEST_N_O)
			wake_q <= 16'h0000;
		else if (wake_q != 16'hFFFF)
			wake_q <= wake_q + 16'h0001;
	end
	read_write_excl_a: assert property (!OE_N_O |-> WE_N_O)
		else $error("output strobe low in a write");
	write_select_a: assert property (!WE_N_O |-> !CHIP_SELECT_FIRST_N_O && CHIP_SELECT_SECOND_O)
		else $error("write without select");
	host_drive_a: assert property (DQ_OE_O |-> OE_N_O)
		else $error("host drives data during read");
	sleep_quiet_a: assert property (!SLEEP_REQUEST_N_O |-> CHIP_SELECT_FIRST_N_O && !CHIP_SELECT_SECOND_O)
		else $error("select while sleeping");
	asleep_ready_a: assert property (ASLEEP_O |-> !REQ_READY_O)
		else $error("ready while asleep");
	busy_quiet_a: assert property (!STORE_BUSY_N_I [*8] |-> CHIP_SELECT_FIRST_N_O)
		else $error("access while busy");
	wake_delay_a: assert property (REQ_READY_O |-> wake_q >= WAKE_CYCLES - 1)
		else $error("ready too soon after wake");
	sleep_cause_a: assert property ($fell(SLEEP_REQUEST_N_O) |-> $past(SLEEP_REQ_I))
		else $error("sleep pin low without request");
endmodule
bind nvmc_ctrl nvmc_ctrl_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) mon (.*);
`default_nettype wire

// ### testbench/nvmc_ctrl_test.sv
// Purpose: Self-checking bench of the nonvolatile SRAM controller
// Assumes: Device model on the pins
// Notes:   Short wake count keeps the run brief
`default_nettype none
module nvmc_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	import nvmc_pkg::*;
	localparam int WAKE = 4;
	logic        clk = 1'b0;
	logic        rst_n, valid, sleep, ready, rsp, as_on, asleep, cs2, pdq_oe, dev_as;
	logic        cs1_n, we_n, oe_n, ub_n, lb_n, zz_n, busy_n, ex_as;
	nvmc_op_t    op;
	logic [20:0] addr, paddr;
	logic [15:0] wdata, rdata, pdq, dev_dq, dq_in;
	logic [1:0]  be;
	logic [15:0] em [int];
	logic [15:0] en [int];
	nvmc_op_t    ops [4] = '{NVMC_OP_SAVE, NVMC_OP_AS_OFF, NVMC_OP_RESTORE, NVMC_OP_AS_ON};
	int          n_fail = 0;
	int          comparisons = 0;
	int          n;
	assign dq_in = pdq_oe ? pdq : dev_dq;
	nvmc_ctrl #(.WAKE_CYCLES(WAKE), .WIDE16(1'b1)) dut (
		.SYS_CLK_I(clk), .RSTN_I(rst_n), .REQ_VALID_I(valid), .REQ_OP_I(op),
		.REQ_ADDR_I(addr), .REQ_WDATA_I(wdata), .REQ_BE_I(be), .REQ_READY_O(ready),
		.RSP_VALID_O(rsp), .RSP_RDATA_O(rdata), .AUTOSAVE_ON_O(as_on),
		.SLEEP_REQ_I(sleep), .ASLEEP_O(asleep), .CHIP_SELECT_FIRST_N_O(cs1_n),
		.CHIP_SELECT_SECOND_O(cs2), .WE_N_O(we_n), .OE_N_O(oe_n),
		.UPPER_BYTE_ENABLE_N_O(ub_n), .LOWER_BYTE_ENABLE_N_O(lb_n), .ADDR_O(paddr),
		.DQ_O(pdq), .DQ_OE_O(pdq_oe), .DQ_I(dq_in), .SLEEP_REQUEST_N_O(zz_n),
		.STORE_BUSY_N_I(busy_n));
	nvmc_dev_model dev (
		.clk_i(clk), .cs1_n_i(cs1_n), .cs2_i(cs2), .we_n_i(we_n), .oe_n_i(oe_n),
		.be_n_i({ub_n, lb_n}), .addr_i(paddr), .dq_i(pdq), .sleep_n_i(zz_n),
		.dq_o(dev_dq), .busy_n_o(busy_n), .autosave_o(dev_as));
	always #10 clk = ~clk;
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask
	// Bounded wait so a hung handshake ends the run
	task automatic hold(input logic [2:0] w);
		n = 0;
		while ({ready, rsp, asleep} !== w && n < 5000) begin
			@(posedge clk);
			#2;
			n++;
		end
		if (n >= 5000) begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic req(nvmc_op_t o, logic [20:0] a, logic [15:0] d, logic [1:0] b);
		hold(3'b100);
		op = o;
		{valid, addr, wdata, be} = {1'b1, a, d, b};
		@(posedge clk);
		#2;
		valid = 1'b0;
		hold(3'b110);
	endtask
	task automatic wr(input logic [20:0] a, input logic [15:0] d, input logic [1:0] b);
		em[a] = em.exists(a) ? em[a] : 16'h0000;
		if (b[0])
			em[a][7:0] = d[7:0];
		if (b[1])
			em[a][15:8] = d[15:8];
		req(NVMC_OP_WRITE, a, d, b);
	endtask
	task automatic rd(input logic [20:0] a);
		req(NVMC_OP_READ, a, 16'h0000, 2'h3);
		chk(rdata, em.exists(a) ? em[a] : 16'h0000);
	endtask
	initial begin
		#1_000_000;
		n_fail++;
		complete_run();
	end
	initial begin
		{rst_n, valid, sleep, addr, wdata, be} = '0;
		op = NVMC_OP_READ;
		ex_as = 1'b1;
		void'($urandom(65158));
		repeat (8) @(posedge clk);
		#2;
		rst_n = 1'b1;
		@(posedge clk);
		#2;
		chk_flag(as_on, 1'b1);
		chk_flag(cs1_n, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			addr = 21'($urandom_range(31));
			wr(addr, 16'($urandom), 2'($urandom_range(3, 1)));
			rd(addr);
		end
		rd(21'h00_0100);
		wr(CLK_REG_BASE16, 16'h00A5, 2'h3);
		rd(CLK_REG_BASE16);
		$display("test access done");
		foreach (ops[i]) begin
			wr(21'h00_0010, 16'($urandom), 2'h3);
			req(ops[i], 21'h00_0000, 16'h0000, 2'h0);
			if (ops[i] == NVMC_OP_RESTORE)
				em = en;
			else
				en = em;
			ex_as = ops[i] == NVMC_OP_AS_OFF ? 1'b0 : ops[i] == NVMC_OP_AS_ON ? 1'b1 : ex_as;
			chk_flag(as_on, ex_as);
			chk_flag(dev_as, ex_as);
			rd(21'h00_0010);
		end
		$display("test commands done");
		wr(21'h00_0020, 16'h5A5A, 2'h3);
		sleep = 1'b1;
		hold(3'b001);
		repeat (2) @(posedge clk);
		#2;
		chk_flag(zz_n, 1'b0);
		chk_flag(ready, 1'b0);
		repeat (20) @(posedge clk);
		#2;
		sleep = 1'b0;
		hold(3'b100);
		chk_flag(n >= WAKE - 1, 1'b1);
		rd(21'h00_0020);
		$display("test sleep done");
		complete_run();
	end
endmodule
`default_nettype wire

// ### testbench/nvmc_dev_model.sv
// Purpose: Behavioural nonvolatile SRAM at the pins
// Assumes: Sampled on the host clock, word organisation
// Notes:   Save and restore hold busy low a fixed span
`default_nettype none
module nvmc_dev_model
	import nvmc_pkg::*;
(
	// Host pins
	input  wire logic        clk_i,
	input  wire logic        cs1_n_i,
	input  wire logic        cs2_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic [1:0]  be_n_i,
	input  wire logic [20:0] addr_i,
	input  wire logic [15:0] dq_i,
	input  wire logic        sleep_n_i,
	// Device outputs
	output logic [15:0]      dq_o,
	output logic             busy_n_o,
	output logic             autosave_o
);
	logic [15:0] mem [int];
	logic [15:0] nv [int];
	logic [12:0] seq [$];
	logic [15:0] pre [5] = '{SEQ_0, SEQ_1, SEQ_2, SEQ_3, SEQ_4};
	logic [15:0] last = 16'h0000;
	logic        rd_q = 1'b0;
	logic        wl = 1'b0;
	logic        ok;
	int          busy = 0;
	// select gated by sleep and busy
	wire         sel = !cs1_n_i && cs2_i && sleep_n_i && busy == 0;
	wire         rd = sel && we_n_i && !oe_n_i;
	assign busy_n_o = busy == 0;
	// released bus shows inverse of last data
	always @(rd or addr_i) begin
		if (rd)
			last = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
		dq_o = rd ? last : ~last;
	end
	// shipped with autosave on, cells zero
	initial autosave_o = 1'b1;
	always @(posedge clk_i) begin
		rd_q <= rd;
		if (busy > 0)
			busy <= busy - 1;
		// sleep entry saves only after a write
		if (!sleep_n_i && wl) begin
			nv = mem;
			wl = 1'b0;
			busy <= 12;
		end
		// byte lanes; a write aborts a sequence
		if (sel && !we_n_i) begin
			if (!mem.exists(addr_i))
				mem[addr_i] = 16'h0000;
			if (!be_n_i[0])
				mem[addr_i][7:0] = dq_i[7:0];
			if (!be_n_i[1])
				mem[addr_i][15:8] = dq_i[15:8];
			wl = 1'b1;
			seq.delete();
		end
		// only bits 14..2 of each read start
		if (rd && !rd_q) begin
			seq.push_back(addr_i[14:2]);
			if (seq.size() > 6)
				void'(seq.pop_front());
			ok = seq.size() == 6;
			for (int i = 0; i < 5; i++)
				ok = ok && seq[i] == pre[i][14:2];
			if (ok) begin
				if (seq[5] == CMD_AS_OFF[14:2])
					autosave_o = 1'b0;
				if (seq[5] == CMD_AS_ON[14:2])
					autosave_o = 1'b1;
				if (seq[5] == CMD_SAVE[14:2])
					nv = mem;
				if (seq[5] == CMD_RESTORE[14:2])
					mem = nv;
				if (seq[5] == CMD_SAVE[14:2] || seq[5] == CMD_RESTORE[14:2]) begin
					wl = 1'b0;
					busy <= 12;
				end
				seq.delete();
			end
		end
	end
endmodule
`default_nettype wire
